// file: sfr_slice_pkg.sv
// Register map, field layout, command codes and timing of the SFR slice.
// Assumes a byte-wide SFR bus at the core's clock.
package sfr_slice_pkg;
  localparam logic [7:0] ADDR_OPTION     = 8'h94;
  localparam logic [7:0] ADDR_FLAGS      = 8'h95;
  localparam logic [7:0] ADDR_WAKE       = 8'h96;
  localparam logic [7:0] ADDR_COMMAND    = 8'h97;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h98;
  // Option register fields
  localparam int CONV_DIV_LSB = 2;
  localparam int TICK_SEL_LSB = 0;
  localparam logic [1:0] CONV_DIV_RESET = 2'h0;
  localparam logic [1:0] TICK_SEL_RESET = 2'h0;
  // Flag register bit positions
  localparam int FLAG_LOW_VOLTAGE = 7;
  localparam int FLAG_TOUCH       = 5;
  localparam int FLAG_CONVERTER   = 4;
  localparam int FLAG_EXT_EDGE    = 2;
  localparam int FLAG_PORT1       = 1;
  localparam int FLAG_TICK        = 0;
  localparam logic [7:0] FLAG_WRITABLE = 8'h37;
  localparam logic [7:0] WAKE_RESET    = 8'h00;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  // Command codes
  localparam logic [7:0] CMD_SOFT_RESET = 8'h56;
  localparam logic [7:0] CMD_SELFPROG   = 8'h65;
  // Converter clock divider terminal counts
  localparam logic [4:0] CONV_DIV32 = 5'h1F;
  localparam logic [4:0] CONV_DIV16 = 5'h0F;
  localparam logic [4:0] CONV_DIV8  = 5'h07;
  localparam logic [4:0] CONV_DIV4  = 5'h03;
  // Tick periods in slow clock cycles
  localparam logic [14:0] TICK_32768 = 15'h7FFF;
  localparam logic [14:0] TICK_16384 = 15'h3FFF;
  localparam logic [14:0] TICK_8192  = 15'h1FFF;
  localparam logic [14:0] TICK_128   = 15'h007F;
  localparam int SOFT_RESET_CYCLES   = 4;
endpackage

// file: sync_edge.sv
// Two-flop synchroniser with edge outputs for one pin.
// Assumes the pin is asynchronous to clock.
module sync_edge (
  // Clock and reset
  input  wire logic clock,
  input  wire logic arst_n,
  // Pin and results
  input  wire logic pin,
  output logic      level,
  output logic      fall,
  output logic      change
);
  logic meta;
  logic stable;
  logic last;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta   <= 1'b1;
      stable <= 1'b1;
      last   <= 1'b1;
    end else begin
      meta   <= pin;
      stable <= meta;
      last   <= stable;
    end
  end

  assign level  = stable;
  assign fall   = last & ~stable;
  assign change = last ^ stable;
endmodule

// file: tick_timer.sv
// Tick timer on slow clock enables, period picked by a two-bit code.
// Assumes slow_en is a one-cycle pulse on the system clock.
module tick_timer (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // Control
  input  wire logic       slow_en,
  input  wire logic [1:0] rate_sel,
  // Event
  output logic            tick
);
  logic [14:0] count;
  logic [14:0] limit;

  always_comb begin
    case (rate_sel)
      2'h0:    limit = sfr_slice_pkg::TICK_32768;
      2'h1:    limit = sfr_slice_pkg::TICK_16384;
      2'h2:    limit = sfr_slice_pkg::TICK_8192;
      default: limit = sfr_slice_pkg::TICK_128;
    endcase
  end

  // Count restarts past the limit so a shortened period takes at once
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count <= 15'h0000;
      tick  <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (slow_en) begin
        if (count >= limit) begin
          count <= 15'h0000;
          tick  <= 1'b1;
        end else begin
          count <= count + 15'h0001;
        end
      end
    end
  end
endmodule

// file: irq_flags_and_system_cmd_regs.sv
// Option, interrupt flag, port-1 wake and system command registers.
// Assumes an SFR bus from the core on the same clock, read data one
// cycle after the read strobe, and engine events as one-cycle pulses.
//
// Added by the designer: the address-and-strobe port.
module irq_flags_and_system_cmd_regs (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // SFR bus
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Slow clock enable and converter clock enable
  input  wire logic       slow_en,
  output logic            converter_clk_en,
  // Engine events and modes
  input  wire logic       converter_done,
  input  wire logic       converter_conversion_start,
  input  wire logic       touch_done,
  input  wire logic       touch_event,
  input  wire logic       touch_conversion_start,
  input  wire logic       automatic_touch_scan_mode,
  // Low-voltage detector and power modes
  input  wire logic       low_voltage_detect,
  input  wire logic       low_voltage_reset_level,
  input  wire logic       low_supply_mode,
  input  wire logic       power_save_mode,
  input  wire logic       stop_mode,
  // Pins
  input  wire logic       ext_irq2_pin,
  input  wire logic [7:0] port1_pins,
  // Service routine acknowledges
  input  wire logic       ack_tick,
  input  wire logic       ack_ext_edge,
  input  wire logic       ack_port1,
  input  wire logic       ack_touch,
  // Results
  output logic      [1:0] tick_timer_rate_sel,
  output logic      [7:0] port1_wake_enable,
  output logic            flash_selfprog_permission_flag,
  output logic            soft_reset_command,
  output logic            irq
);
  logic [1:0] converter_clock_divider_sel;
  logic       tick_timer_flag;
  logic       touch_key_flag;
  logic       converter_done_flag;
  logic       ext_irq2_edge_flag;
  logic       port1_change_flag;
  logic       low_voltage_flag;
  logic [7:0] irq_mask;
  logic [7:0] flag_view;
  logic [4:0] div_count;
  logic [4:0] div_limit;
  logic [2:0] rst_count;
  logic       tick;
  logic       edge_fall;
  logic [7:0] p1_change;
  logic       p1_armed_change;
  logic       lv_meta;
  logic       lv_stable;
  logic [7:0] option_view;
  logic       option_wr;
  logic       flags_wr;
  logic       wake_wr;
  logic       cmd_wr;
  logic       mask_wr;

  // Exact address decode shared by every write enable; the read mux decodes addr in its own case
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  function automatic logic wclr(input logic en, input logic [7:0] d,
                                input int b);
    wclr = en & ~d[b];
  endfunction

  assign option_wr = wr & hit(addr, sfr_slice_pkg::ADDR_OPTION);
  assign flags_wr  = wr & hit(addr, sfr_slice_pkg::ADDR_FLAGS);
  assign wake_wr   = wr & hit(addr, sfr_slice_pkg::ADDR_WAKE);
  assign cmd_wr    = wr & hit(addr, sfr_slice_pkg::ADDR_COMMAND);
  assign mask_wr   = wr & hit(addr, sfr_slice_pkg::ADDR_IRQ_MASK);
  // Only pins with wake enabled may raise the change flag
  assign p1_armed_change = |(p1_change & port1_wake_enable);

  sync_edge u_ext_irq2_pin (
    .clock  (clock),
    .arst_n (arst_n),
    .pin    (ext_irq2_pin),
    .level  (),
    .fall   (edge_fall),
    .change ()
  );

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_p1
      sync_edge u_p1 (
        .clock  (clock),
        .arst_n (arst_n),
        .pin    (port1_pins[gi]),
        .level  (),
        .fall   (),
        .change (p1_change[gi])
      );
    end
  endgenerate

  tick_timer u_tick (
    .clock    (clock),
    .arst_n   (arst_n),
    .slow_en  (slow_en),
    .rate_sel (tick_timer_rate_sel),
    .tick     (tick)
  );

  // Option register fields
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      converter_clock_divider_sel <= sfr_slice_pkg::CONV_DIV_RESET;
      tick_timer_rate_sel         <= sfr_slice_pkg::TICK_SEL_RESET;
    end else if (option_wr) begin
      converter_clock_divider_sel <=
        wdata[sfr_slice_pkg::CONV_DIV_LSB +: 2];
      tick_timer_rate_sel <= wdata[sfr_slice_pkg::TICK_SEL_LSB +: 2];
    end
  end

  // Converter clock divider
  always_comb begin
    case (converter_clock_divider_sel)
      2'h0:    div_limit = sfr_slice_pkg::CONV_DIV32;
      2'h1:    div_limit = sfr_slice_pkg::CONV_DIV16;
      2'h2:    div_limit = sfr_slice_pkg::CONV_DIV8;
      default: div_limit = sfr_slice_pkg::CONV_DIV4;
    endcase
  end

  // Restarts past a lowered limit, so a new rate takes at once
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_count        <= 5'h00;
      converter_clk_en <= 1'b0;
    end else if (div_count >= div_limit) begin
      div_count        <= 5'h00;
      converter_clk_en <= 1'b1;
    end else begin
      div_count        <= div_count + 5'h01;
      converter_clk_en <= 1'b0;
    end
  end

  // Hardware set wins over every clear in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_timer_flag <= 1'b0;
    end else if (tick) begin
      tick_timer_flag <= 1'b1;
    end else if (ack_tick ||
                 wclr(flags_wr, wdata, sfr_slice_pkg::FLAG_TICK)) begin
      tick_timer_flag <= 1'b0;
    end
  end

  // Touch conversion done in manual mode, touch event in automatic mode
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      touch_key_flag <= 1'b0;
    end else if (automatic_touch_scan_mode ? touch_event : touch_done) begin
      touch_key_flag <= 1'b1;
    end else if (wclr(flags_wr, wdata, sfr_slice_pkg::FLAG_TOUCH) ||
                 (!automatic_touch_scan_mode && touch_conversion_start) ||
                 (automatic_touch_scan_mode && ack_touch)) begin
      touch_key_flag <= 1'b0;
    end
  end

  // Converter start clears the converter flag only, never the touch flag
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      converter_done_flag <= 1'b0;
    end else if (converter_done) begin
      converter_done_flag <= 1'b1;
    end else if (converter_conversion_start ||
                 wclr(flags_wr, wdata, sfr_slice_pkg::FLAG_CONVERTER)) begin
      converter_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ext_irq2_edge_flag <= 1'b0;
    end else if (edge_fall) begin
      ext_irq2_edge_flag <= 1'b1;
    end else if (ack_ext_edge ||
                 wclr(flags_wr, wdata, sfr_slice_pkg::FLAG_EXT_EDGE)) begin
      ext_irq2_edge_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      port1_change_flag <= 1'b0;
    end else if (p1_armed_change) begin
      port1_change_flag <= 1'b1;
    end else if (ack_port1 ||
                 wclr(flags_wr, wdata, sfr_slice_pkg::FLAG_PORT1)) begin
      port1_change_flag <= 1'b0;
    end
  end

  // Detector is analog and free-running, so two flops come first
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lv_meta   <= 1'b0;
      lv_stable <= 1'b0;
    end else begin
      lv_meta   <= low_voltage_detect;
      lv_stable <= lv_meta;
    end
  end

  // Mode levels come from logic on this clock and need no synchroniser
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      low_voltage_flag <= 1'b0;
    end else begin
      low_voltage_flag <= lv_stable & low_voltage_reset_level &
                          ~stop_mode &
                          ~(low_supply_mode & power_save_mode);
    end
  end

  // Enables gate the change flag only; pin sampling never stops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      port1_wake_enable <= sfr_slice_pkg::WAKE_RESET;
    end else if (wake_wr) begin
      port1_wake_enable <= wdata;
    end
  end

  // Mask bit 7 stays zero: the detector bit is a level, not an event
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask <= sfr_slice_pkg::MASK_RESET;
    end else if (mask_wr) begin
      irq_mask <= wdata & sfr_slice_pkg::FLAG_WRITABLE;
    end
  end

  // Any other command value, 56h too, withdraws the permission
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flash_selfprog_permission_flag <= 1'b0;
    end else if (cmd_wr) begin
      flash_selfprog_permission_flag <=
        (wdata == sfr_slice_pkg::CMD_SELFPROG);
    end
  end

  // Reset pulse held a few cycles so every reset target sees it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_count          <= 3'h0;
      soft_reset_command <= 1'b0;
    end else if (cmd_wr && wdata == sfr_slice_pkg::CMD_SOFT_RESET) begin
      rst_count <= 3'(sfr_slice_pkg::SOFT_RESET_CYCLES - 1);
      soft_reset_command <= 1'b1;
    end else if (rst_count != 3'h0) begin
      rst_count <= rst_count - 3'h1;
    end else begin
      soft_reset_command <= 1'b0;
    end
  end

  // Option bits 7 to 4 belong to other blocks and read zero here
  always_comb begin
    option_view = 8'h00;
    option_view[sfr_slice_pkg::CONV_DIV_LSB +: 2] =
      converter_clock_divider_sel;
    option_view[sfr_slice_pkg::TICK_SEL_LSB +: 2] = tick_timer_rate_sel;
  end

  // Bits 6 and 3 are unused and read zero
  always_comb begin
    flag_view = 8'h00;
    flag_view[sfr_slice_pkg::FLAG_LOW_VOLTAGE] = low_voltage_flag;
    flag_view[sfr_slice_pkg::FLAG_TOUCH]       = touch_key_flag;
    flag_view[sfr_slice_pkg::FLAG_CONVERTER]   = converter_done_flag;
    flag_view[sfr_slice_pkg::FLAG_EXT_EDGE]    = ext_irq2_edge_flag;
    flag_view[sfr_slice_pkg::FLAG_PORT1]       = port1_change_flag;
    flag_view[sfr_slice_pkg::FLAG_TICK]        = tick_timer_flag;
  end

  // Registered output, so it trails the flags by one cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flag_view & irq_mask);
    end
  end

  // Read data; unmapped addresses and other option bits read zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        sfr_slice_pkg::ADDR_OPTION:   rdata <= option_view;
        sfr_slice_pkg::ADDR_FLAGS:    rdata <= flag_view;
        sfr_slice_pkg::ADDR_WAKE:     rdata <= port1_wake_enable;
        sfr_slice_pkg::ADDR_COMMAND: begin
          rdata <= {7'h00, flash_selfprog_permission_flag};
        end
        sfr_slice_pkg::ADDR_IRQ_MASK: rdata <= irq_mask;
        default:                      rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

// file: sfr_slice_properties.sv
// Concurrent checks for the SFR slice, seeing its top-level ports only.
// Assumes sfr_slice_pkg is compiled first and one clock domain.
module sfr_slice_props (
  // Clock and reset
  input wire logic       clock,
  input wire logic       arst_n,
  // Bus
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // Observed
  input wire logic       converter_clk_en,
  input wire logic       stop_mode,
  input wire logic [1:0] tick_timer_rate_sel,
  input wire logic [7:0] port1_wake_enable,
  input wire logic       flash_selfprog_permission_flag,
  input wire logic       soft_reset_command
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic       opt_wr;
  logic [1:0] div_sel;
  logic       seen;
  logic [5:0] gap;
  assign opt_wr = wr && addr == sfr_slice_pkg::ADDR_OPTION;
  // First pulse after a rate change may be short, so it is not judged
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_sel <= 2'h0;
      seen    <= 1'b0;
      gap     <= 6'h00;
    end else begin
      gap <= converter_clk_en ? 6'h00 : gap + 6'h01;
      if (opt_wr) begin
        div_sel <= wdata[3:2];
        seen    <= 1'b0;
      end else if (converter_clk_en) begin
        seen <= 1'b1;
      end
    end
  end
  chk_conv_div_gap: assert property (
    converter_clk_en && seen |-> gap == (6'h20 >> div_sel) - 6'h01)
    else $error("converter clock pulse spacing wrong");
  chk_tick_rate_sel: assert property (
    opt_wr |=> tick_timer_rate_sel == $past(wdata[1:0]))
    else $error("tick rate select not written");
  chk_wake_write: assert property (
    wr && addr == 8'h96 |=> port1_wake_enable == $past(wdata))
    else $error("wake enables not written");
  chk_wake_read: assert property (
    rd && addr == 8'h96 |=> rdata == $past(port1_wake_enable))
    else $error("wake enables read back wrong");
  chk_selfprog_set: assert property (
    wr && addr == 8'h97 |=>
      flash_selfprog_permission_flag == ($past(wdata) == 8'h65))
    else $error("self-programming flag wrong after command");
  chk_selfprog_read: assert property (
    rd && addr == 8'h97 |=> rdata[0] == $past(flash_selfprog_permission_flag))
    else $error("self-programming flag read back wrong");
  chk_soft_reset_pulse: assert property (
    wr && addr == 8'h97 && wdata == 8'h56 |=> soft_reset_command [*4])
    else $error("soft reset command missing");
  chk_lv_stop_quiet: assert property (
    rd && addr == 8'h95 && $past(stop_mode) && stop_mode |=> !rdata[7])
    else $error("low-voltage flag seen in stop mode");
  cover property (soft_reset_command);
  cover property (flash_selfprog_permission_flag);
  cover property (rd && addr == 8'h95 ##1 rdata[0]);
endmodule

// file: core_bus_model.sv
// Behavioural core side of the SFR bus: single-byte writes and reads.
// Assumes the slave answers in the cycle after the read strobe.
module core_bus_model (
  // Clock
  input  wire logic       clock,
  // Bus
  output logic      [7:0] addr = 8'h00,
  output logic      [7:0] wdata = 8'h00,
  output logic            wr = 1'b0,
  output logic            rd = 1'b0,
  input  wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask
  // Data taken at the edge closing the answer cycle
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    @(posedge clock);
    d = rdata;
  endtask
endmodule

// file: irq_flags_and_system_cmd_regs_tb.sv
// Self-checking bench for the SFR slice, core side modelled.
// Assumes the design and checker files are compiled before it.
module irq_flags_and_system_cmd_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock = 1'b0;
  logic       arst_n = 1'b0;
  logic       slow_en = 1'b0;
  logic       auto = 1'b0;
  logic       ext_pin = 1'b1;
  logic [8:0] ev = 9'h000;
  logic [4:0] pw = 5'h00;
  logic [7:0] p1 = 8'hFF;
  logic [7:0] addr, wdata, rdata, wake, got;
  logic       wr, rd, cclk, sp, srst, irq;
  logic [1:0] rate;
  int         bad_count = 0;
  int         total_checks = 0;
  core_bus_model core (.clock, .addr, .wdata, .wr, .rd, .rdata);
  irq_flags_and_system_cmd_regs dut (
    .clock, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .slow_en,
    .converter_clk_en(cclk), .converter_done(ev[0]),
    .converter_conversion_start(ev[1]), .touch_done(ev[2]),
    .touch_event(ev[3]), .touch_conversion_start(ev[4]),
    .automatic_touch_scan_mode(auto), .low_voltage_detect(pw[0]),
    .low_voltage_reset_level(pw[1]), .low_supply_mode(pw[2]),
    .power_save_mode(pw[3]), .stop_mode(pw[4]), .ext_irq2_pin(ext_pin),
    .port1_pins(p1), .ack_tick(ev[5]), .ack_ext_edge(ev[6]),
    .ack_port1(ev[7]), .ack_touch(ev[8]), .tick_timer_rate_sel(rate),
    .port1_wake_enable(wake), .flash_selfprog_permission_flag(sp),
    .soft_reset_command(srst), .irq);
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    core.read(a, got);
    check(got, e);
  endtask
  task automatic pulse(input int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev[i] <= 1'b0;
  endtask
  task automatic t_reset;
    rd_chk(8'h94, 8'h00);
    rd_chk(8'h95, 8'h00);
    rd_chk(8'h96, 8'h00);
    rd_chk(8'h97, 8'h00);
    rd_chk(8'h90, 8'h00);
  endtask
  task automatic t_option;
    for (int s = 0; s < 4; s++) begin
      core.write(8'h94, {4'h0, s[1:0], s[1:0]});
      repeat (80) @(posedge clock);
      rd_chk(8'h94, {4'h0, s[1:0], s[1:0]});
      check({6'h00, rate}, {6'h00, s[1:0]});
    end
  endtask
  // Rate 128: ticks fall at 128 and 256 slow pulses
  task automatic t_tick;
    core.write(8'h98, 8'h01);
    for (int k = 0; k < 2; k++) begin
      slow_en <= 1'b1;
      repeat (120) @(posedge clock);
      slow_en <= 1'b0;
      rd_chk(8'h95, 8'h00);
      slow_en <= 1'b1;
      repeat (10) @(posedge clock);
      slow_en <= 1'b0;
      rd_chk(8'h95, 8'h01);
      check({7'h00, irq}, 8'h01);
      if (k == 0) pulse(5);
      else core.write(8'h95, 8'hFE);
      rd_chk(8'h95, 8'h00);
      check({7'h00, irq}, 8'h00);
    end
    core.write(8'h98, 8'h00);
  endtask
  task automatic t_flags;
    core.write(8'h96, 8'h08);
    pulse(0);
    check(wake, 8'h08);
    pulse(2);
    ext_pin <= 1'b0;
    p1 <= 8'hF6;
    repeat (6) @(posedge clock);
    rd_chk(8'h95, 8'h36);
    core.write(8'h95, 8'hDF);
    rd_chk(8'h95, 8'h16);
    core.write(8'h95, 8'hEF);
    rd_chk(8'h95, 8'h06);
    pulse(6);
    rd_chk(8'h95, 8'h02);
    core.write(8'h95, 8'hFD);
    p1 <= 8'hF7;
    ext_pin <= 1'b1;
    repeat (6) @(posedge clock);
    rd_chk(8'h95, 8'h00);
    p1 <= 8'hFF;
    ext_pin <= 1'b0;
    core.write(8'h98, 8'h04);
    repeat (6) @(posedge clock);
    rd_chk(8'h95, 8'h06);
    check({7'h00, irq}, 8'h01);
    pulse(7);
    core.write(8'h95, 8'hFB);
    rd_chk(8'h95, 8'h00);
    check({7'h00, irq}, 8'h00);
    pulse(0);
    pulse(1);
    pulse(2);
    pulse(4);
    rd_chk(8'h95, 8'h00);
    auto <= 1'b1;
    pulse(3);
    rd_chk(8'h95, 8'h20);
    pulse(8);
    rd_chk(8'h95, 8'h00);
    pulse(3);
    core.write(8'h95, 8'hDF);
    rd_chk(8'h95, 8'h00);
    auto <= 1'b0;
    ext_pin <= 1'b1;
    core.write(8'h98, 8'h00);
  endtask
  // Cases: enabled, stop, both save modes, other reset level
  task automatic t_lv;
    logic [4:0] c [4] = '{5'h03, 5'h13, 5'h0F, 5'h01};
    logic [7:0] e [4] = '{8'h80, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 4; i++) begin
      pw <= c[i];
      repeat (3) @(posedge clock);
      rd_chk(8'h95, e[i]);
    end
    pw <= 5'h00;
  endtask
  task automatic t_cmd;
    core.write(8'h97, 8'h65);
    rd_chk(8'h97, 8'h01);
    check({7'h00, sp}, 8'h01);
    core.write(8'h97, 8'h00);
    rd_chk(8'h97, 8'h00);
    core.write(8'h97, 8'h65);
    core.write(8'h97, 8'h56);
    @(posedge clock);
    check({7'h00, srst}, 8'h01);
    rd_chk(8'h97, 8'h00);
    @(posedge clock);
    check({7'h00, srst}, 8'h00);
  endtask
  task automatic conclude;
    $display("Checks: %0d, mismatches: %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    t_reset;
    t_option;
    t_tick;
    t_flags;
    t_lv;
    t_cmd;
    conclude;
  end
  // Whole run needs about 800 cycles
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    conclude;
  end
endmodule
bind irq_flags_and_system_cmd_regs sfr_slice_props chk (
  .clock, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .converter_clk_en,
  .stop_mode, .tick_timer_rate_sel, .port1_wake_enable,
  .flash_selfprog_permission_flag, .soft_reset_command);
